/* wl_device.sv */
// Write-leveling feedback and bring-up tracking inside the memory device.
// Assumes the controller keeps its own sequencing; all pins are asynchronous.
`timescale 1ns/1ps
module wl_device
    import wl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    // Device pins in
    input wire logic reset_pin_n,
    input wire logic cke,
    input wire logic odt,
    input wire logic ck,
    input wire logic [LANES-1:0] dqs,
    // Device pins out
    output logic [DQ_W-1:0] dq_out,
    output logic [DQ_W-1:0] dq_oe,
    output logic [LANES-1:0] dqs_term_en
);
    // ========================================
    // Pin synchronisers
    logic [4+LANES-1:0] pin_lvl;
    logic [4+LANES-1:0] pin_rise;
    wl_sync #(.W(4 + LANES)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({dqs, ck, odt, cke, reset_pin_n}),
        .level(pin_lvl),
        .rise(pin_rise)
    );
    logic resetn_s;
    logic cke_s;
    logic odt_s;
    logic ck_s;
    logic ck_rise;
    logic [LANES-1:0] dqs_rise;
    assign resetn_s = pin_lvl[0];
    assign cke_s = pin_lvl[1];
    assign odt_s = pin_lvl[2];
    assign ck_s = pin_lvl[3];
    assign ck_rise = pin_rise[3];
    assign dqs_rise = pin_rise[4 +: LANES];

    // ========================================
    // Control register
    logic [6:0] ctrl_r;
    logic level_en;
    logic outbuf_off;
    logic wide16;
    logic [CTRL_TERM_W-1:0] term_code;
    logic ctrl_wr;
    assign ctrl_wr = wr_stb && (addr == ADDR_CTRL);
    assign level_en = ctrl_r[CTRL_LEVEL_EN];
    assign outbuf_off = ctrl_r[CTRL_OUTBUF_OFF];
    assign wide16 = ctrl_r[CTRL_WIDE16];
    assign term_code = ctrl_r[CTRL_TERM_LSB +: CTRL_TERM_W];
    // Mode bits written by software, lost while RESET# pin low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET_VAL;
        end else if (!resetn_s) begin
            ctrl_r <= CTRL_RESET_VAL;
        end else if (ctrl_wr) begin
            ctrl_r <= wdata[6:0];
        end else begin
            ctrl_r[CTRL_DLL_RESET] <= 1'b0; // Self-clearing
        end
    end

    // ========================================
    // CKE seen high since RESET# release
    logic cke_seen_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cke_seen_r <= 1'b0;
        end else if (!resetn_s) begin
            cke_seen_r <= 1'b0;
        end else if (cke_s) begin
            cke_seen_r <= 1'b1;
        end
    end

    // ========================================
    // DLL lock counter on input clock edges
    logic [9:0] dll_cnt_r;
    logic dll_locked_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dll_cnt_r <= CNT_ZERO;
            dll_locked_r <= 1'b0;
        end else if (!resetn_s) begin
            dll_cnt_r <= CNT_ZERO;
            dll_locked_r <= 1'b0;
        end else if (ctrl_r[CTRL_DLL_RESET]) begin
            dll_cnt_r <= DLLK_CK;
            dll_locked_r <= 1'b0;
        end else if (ck_rise && dll_cnt_r != CNT_ZERO) begin
            dll_cnt_r <= dll_cnt_r - CNT_ONE;
            dll_locked_r <= (dll_cnt_r == CNT_ONE);
        end
    end

    // ========================================
    // Leveling exit settle window
    logic level_en_d_r;
    logic [9:0] mod_cnt_r;
    logic settling;
    assign settling = (mod_cnt_r != CNT_ZERO);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_en_d_r <= 1'b0;
            mod_cnt_r <= CNT_ZERO;
        end else begin
            level_en_d_r <= level_en;
            if (level_en_d_r && !level_en) begin
                mod_cnt_r <= MOD_CK;
            end else if (level_en) begin
                mod_cnt_r <= CNT_ZERO;
            end else if (ck_rise && settling) begin
                mod_cnt_r <= mod_cnt_r - CNT_ONE;
            end
        end
    end

    // ========================================
    // Termination legality and strobe termination
    logic term_ok;
    logic term_err_r;
    always_comb begin
        term_ok = (term_code == TERM_40) || (term_code == TERM_60) ||
                  (term_code == TERM_120);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            term_err_r <= 1'b0;
        end else begin
            term_err_r <= level_en && !outbuf_off && !term_ok;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dqs_term_en <= '0;
        end else if (level_en && cke_seen_r && odt_s &&
                     term_code != TERM_OFF) begin
            dqs_term_en <= wide16 ? {LANES{1'b1}} : {{(LANES-1){1'b0}}, 1'b1};
        end else begin
            dqs_term_en <= '0;
        end
    end

    // ========================================
    // Feedback capture per lane
    logic [LANES-1:0] fb_r;
    genvar li;
    generate
        for (li = 0; li < LANES; li++) begin : g_lane
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    fb_r[li] <= 1'b0;
                end else if (!level_en || outbuf_off) begin
                    fb_r[li] <= 1'b0; // strobes ignored
                end else if (dqs_rise[li]) begin
                    fb_r[li] <= ck_s;
                end
            end
        end
    endgenerate

    // ========================================
    // DQ drivers: prime bit per lane, rest low
    logic [DQ_W-1:0] dq_nxt;
    logic [DQ_W-1:0] oe_nxt;
    logic drive;
    assign drive = level_en && !outbuf_off;
    always_comb begin
        dq_nxt = '0;
        oe_nxt = '0;
        if (drive) begin
            dq_nxt[0] = fb_r[0];
            oe_nxt[LANE_W-1:0] = {LANE_W{1'b1}};
            if (wide16) begin
                dq_nxt[LANE_W] = fb_r[1];
                oe_nxt[DQ_W-1:LANE_W] = {LANE_W{1'b1}};
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dq_out <= '0;
            dq_oe <= '0;
        end else begin
            dq_out <= dq_nxt;
            dq_oe <= oe_nxt;
        end
    end

    // ========================================
    // Register read port
    logic [31:0] status;
    always_comb begin
        status = '0;
        status[STAT_DLL_LOCKED] = dll_locked_r;
        status[STAT_SETTLING] = settling;
        status[STAT_TERM_ERR] = term_err_r;
        status[STAT_CKE_SEEN] = cke_seen_r;
        status[STAT_FB_LSB +: LANES] = fb_r;
    end
    // Read data one cycle after strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd_stb) begin
            case (addr)
                ADDR_CTRL: rdata <= {25'h0, ctrl_r};
                ADDR_STATUS: rdata <= status;
                default: rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end
endmodule : wl_device

/* wl_pkg.sv */
// Package for the write-leveling feedback block of the memory device.
// Assumes one 25 MHz core clock and a 4-bit byte-addressed register port.
package wl_pkg;
    // ========================================
    // Register map (byte addresses)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    // ========================================
    // Control fields
    localparam int CTRL_LEVEL_EN = 0;
    localparam int CTRL_OUTBUF_OFF = 1;
    localparam int CTRL_TERM_LSB = 2;
    localparam int CTRL_TERM_W = 3;
    localparam int CTRL_WIDE16 = 5;
    localparam int CTRL_DLL_RESET = 6;
    localparam logic [6:0] CTRL_RESET_VAL = 7'h00;
    // ========================================
    // Status fields
    localparam int STAT_DLL_LOCKED = 0;
    localparam int STAT_SETTLING = 1;
    localparam int STAT_TERM_ERR = 2;
    localparam int STAT_CKE_SEEN = 3;
    localparam int STAT_FB_LSB = 4;
    // ========================================
    // Nominal termination codes
    localparam logic [2:0] TERM_OFF = 3'h0;
    localparam logic [2:0] TERM_60 = 3'h1;
    localparam logic [2:0] TERM_120 = 3'h2;
    localparam logic [2:0] TERM_40 = 3'h3;
    // ========================================
    // Timing, in input clock (CK) cycles
    localparam logic [9:0] DLLK_CK = 10'h200;
    localparam logic [9:0] MOD_CK = 10'h00C;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [9:0] CNT_ONE = 10'h001;
    // Bus and pin widths
    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int LANE_W = 8;
endpackage : wl_pkg

/* wl_sync.sv */
// Two-flop synchroniser with rising-edge pulse, one per input bit.
// Assumes inputs are asynchronous to clk; the first stage feeds only the second.
`timescale 1ns/1ps
module wl_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous inputs
    input wire logic [W-1:0] async_in,
    // Synchronised level and rising edge
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    // ========================================
    // Per-bit synchroniser chain
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic meta_r;
            logic sync_r;
            logic last_r;
            // Two flops then edge history
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    last_r <= 1'b0;
                end else begin
                    meta_r <= async_in[gi];
                    sync_r <= meta_r;
                    last_r <= sync_r;
                end
            end
            assign level[gi] = sync_r;
            assign rise[gi] = sync_r & ~last_r;
        end
    endgenerate
endmodule : wl_sync

/* wl_device_properties.sv */
// Port checker for the write-leveling device block.
// Assumes a bind onto wl_device and a single clock domain.
`timescale 1ns/1ps
module wl_props
    import wl_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    // Device pins
    input wire logic reset_pin_n,
    input wire logic odt,
    input wire logic [LANES-1:0] dqs,
    input wire logic [DQ_W-1:0] dq_out,
    input wire logic [DQ_W-1:0] dq_oe,
    input wire logic [LANES-1:0] dqs_term_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Six cycles with no write and no strobe or RESET# edge
    sequence quiet_s;
        (!wr_stb && $stable(dqs) && $stable(reset_pin_n)) [*6];
    endsequence
    idle_read_a:
        assert property (!rd_stb |=> rdata == 32'h0000_0000) else $error("rdata");
    unmapped_read_a:
        assert property (rd_stb && addr != ADDR_CTRL && addr != ADDR_STATUS
            |=> rdata == 32'h0000_0000) else $error("unmapped read");
    reset_quiet_a:
        assert property ($fell(rst) |-> dq_oe == 16'h0000) else $error("reset");
    oe_shape_a:
        assert property (dq_oe inside {16'h0000, 16'h00ff, 16'hffff})
        else $error("DQ enable shape");
    nonprime_low_a:
        assert property ((dq_out & dq_oe & 16'hfefe) == 16'h0000)
        else $error("non-prime DQ high");
    term_odt_a:
        assert property (!odt [*5] |-> dqs_term_en == 2'b00)
        else $error("termination without ODT");
    pin_reset_a:
        assert property (!reset_pin_n [*5] |-> dqs_term_en == 2'b00
            && dq_oe == 16'h0000) else $error("pins active in pin reset");
    fb_hold_a:
        assert property (quiet_s |-> $stable(dq_out[0]) || !dq_oe[0])
        else $error("feedback moved without strobe");
endmodule : wl_props

bind wl_device wl_props props (.clk, .rst, .addr, .wr_stb, .rd_stb, .rdata,
    .reset_pin_n, .odt, .dqs, .dq_out, .dq_oe, .dqs_term_en);

/* wl_ctrl_model.sv */
// Controller model driving RESET#, CKE, ODT, CK and DQS.
// Assumes the bench calls one task at a time; CK runs free.
`timescale 1ns/1ps
module wl_ctrl_model
    import wl_pkg::*;
(
    // Device pins
    output logic reset_pin_n,
    output logic cke,
    output logic odt,
    output logic ck,
    output logic [LANES-1:0] dqs
);
    // no commands issued, DQ never driven
    initial begin
        reset_pin_n = 1'b0;
        cke = 1'b0;
        odt = 1'b0;
        dqs = '0;
        ck = 1'b0;
        forever #160 ck = ~ck;
    end
    // waits as fixed delays in ns
    // Bring-up with shortened waits
    task automatic bringup();
        cke = 1'b0;
        odt = 1'b0;
        #2000 reset_pin_n = 1'b1;
        #4000 cke = 1'b1;
    endtask : bringup
    task automatic pins(input logic rn, input logic o);
        reset_pin_n = rn;
        odt = o;
    endtask : pins
    task automatic strobe(input int lane, input logic hi);
        if (hi) @(posedge ck);
        else @(negedge ck);
        #40 dqs[lane] = 1'b1;
        #160 dqs[lane] = 1'b0;
        #160;
    endtask : strobe
endmodule : wl_ctrl_model

/* testbench.sv */
// Bench for the write-leveling device: register tasks and pin scenarios.
// Assumes the controller model drives every device input pin.
`timescale 1ns/1ps
module testbench
    import wl_pkg::*;
;
    logic clk, rst, wr_stb, rd_stb;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    logic reset_pin_n, cke, odt, ck;
    logic [LANES-1:0] dqs, dqs_term_en;
    logic [DQ_W-1:0] dq_out, dq_oe;
    int miscompares = 0;
    int n_tests = 0;
    wl_device dut (.clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .reset_pin_n, .cke, .odt, .ck, .dqs, .dq_out, .dq_oe, .dqs_term_en);
    wl_ctrl_model ctrl (.reset_pin_n, .cke, .odt, .ck, .dqs);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] got, e);
        n_tests++;
        if (got !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    // Read, mask and compare
    task automatic rc(input string nm, input logic [3:0] a,
        input logic [31:0] e, m);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk(nm, rdata & m, e);
    endtask : rc
    // Pin compare after settling: 0 data, 1 enables, 2 termination
    task automatic pc(input string nm, input int s, input logic [31:0] e);
        repeat (8) @(posedge clk);
        #1;
        chk(nm, s == 0 ? 32'(dq_out) : s == 1 ? 32'(dq_oe)
            : 32'(dqs_term_en), e);
    endtask : pc
    task automatic summarize();
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        #1_000_000;
        miscompares++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rc("ctrl", ADDR_CTRL, 32'h0000_0000, '1);
        rc("unmapped", 4'h8, 32'h0000_0000, '1);
        wr(ADDR_CTRL, 32'h0000_0001);
        rc("ctrl held", ADDR_CTRL, 32'h0000_0000, '1);
        ctrl.bringup();
        repeat (8) @(posedge clk);
        rc("cke", ADDR_STATUS, 32'h0000_0008, '1);
        // MR0 last: DLL reset, then wait
        wr(ADDR_CTRL, 32'h0000_0040);
        repeat (4064) @(posedge clk);
        rc("dll early", ADDR_STATUS, 32'h0000_0008, 32'h0000_000f);
        repeat (128) @(posedge clk);
        rc("dll lock", ADDR_STATUS, 32'h0000_0009, 32'h0000_000f);
        // Leveling on, outputs on, 40 ohm code
        // leveling only after DLL lock
        wr(ADDR_CTRL, 32'h0000_000d);
        pc("term odt low", 2, 32'h0000_0000);
        ctrl.pins(1'b1, 1'b1);
        pc("term on", 2, 32'h0000_0001);
        ctrl.strobe(0, 1'b1);
        pc("fb high", 0, 32'h0000_0001);
        pc("oe x8", 1, 32'h0000_00ff);
        rc("fb stat", ADDR_STATUS, 32'h0000_0019, 32'h0000_001f);
        ctrl.strobe(0, 1'b0);
        pc("fb low", 0, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_002d);
        ctrl.strobe(1, 1'b1);
        pc("fb x16", 0, 32'h0000_0100);
        pc("oe x16", 1, 32'h0000_ffff);
        pc("term x16", 2, 32'h0000_0003);
        wr(ADDR_CTRL, 32'h0000_0015);
        rc("term err", ADDR_STATUS, 32'h0000_000d, 32'h0000_000f);
        // outputs off, as a rank not leveled
        wr(ADDR_CTRL, 32'h0000_0017);
        ctrl.strobe(0, 1'b1);
        pc("oe off", 1, 32'h0000_0000);
        pc("term any", 2, 32'h0000_0001);
        rc("fb off", ADDR_STATUS, 32'h0000_0009, 32'h0000_003f);
        ctrl.pins(1'b1, 1'b0);
        pc("term odt off", 2, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0000);
        rc("settling", ADDR_STATUS, 32'h0000_000b, 32'h0000_000f);
        repeat (112) @(posedge clk);
        rc("settled", ADDR_STATUS, 32'h0000_0009, 32'h0000_000f);
        ctrl.pins(1'b0, 1'b0);
        repeat (8) @(posedge clk);
        rc("pin reset", ADDR_STATUS, 32'h0000_0000, 32'h0000_000f);
        summarize();
    end
endmodule : testbench
